// [hdl/ocdp_pkg.sv]
package ocdp_pkg;

    // channel count and divider widths
    localparam int NUM_CH        = 16;
    localparam int CD_W          = 12;
    localparam int SD_W          = 20;
    localparam int SRDLY_W       = 3;
    localparam int NUM_PAIR      = 6;

    // sysref request control register
    localparam logic [7:0] SR_CTRL_ADDR  = 8'h1a;
    localparam logic [7:0] SR_CTRL_RESET = 8'h00;
    localparam int         SR_MODE_LSB   = 4;
    localparam int         SR_SEL_LSB    = 2;
    localparam int         SR_PEND_BIT   = 0;
    localparam logic [1:0] SR_MODE_RESAMPLE = 2'h3;

    // channels whose sample tick can resample a sysref request
    localparam logic [3:0] SR_SAMPLE_CH0 = 4'h0;
    localparam logic [3:0] SR_SAMPLE_CH1 = 4'h4;
    localparam logic [3:0] SR_SAMPLE_CH2 = 4'h8;
    localparam logic [3:0] SR_SAMPLE_CH3 = 4'hc;

    // output channel selector
    typedef enum logic [2:0] {
        OCDP_SEL_BYPASS  = 3'h0,
        OCDP_SEL_CHANNEL_DIVIDER_SELECT   = 3'h1,
        OCDP_SEL_HALF    = 3'h2,
        OCDP_SEL_SYSREF  = 3'h3,
        OCDP_SEL_SR_ANALOG_DELAY = 3'h4,
        OCDP_SEL_STATIC  = 3'h5
    } ocdp_sel_e;

    // per channel configuration
    typedef struct packed {
        ocdp_sel_e          channel_divider_select;
        logic [CD_W-1:0]    channel_divide_value;
        logic [SD_W-1:0]    sysref_divide_value;
        logic [CD_W-1:0]    cd_static_delay;
        logic [SD_W-1:0]    sd_static_delay;
        logic [SRDLY_W-1:0] sysref_digital_delay;
        logic               output_driver_enable;
        logic               divider_power_down;
        logic               sync_enable;
    } ocdp_ch_cfg_s;

    // differential output pin pair
    typedef struct packed {
        logic positive_leg;
        logic negative_leg;
        logic oe;
    } ocdp_leg_s;

    // channel owns a sysref divider
    function automatic logic ocdp_has_sr(input int ch);
        return !(ch == 2 || ch == 3 || ch == 14 || ch == 15);
    endfunction

    // pair index of a sysref channel for replication enables
    function automatic int ocdp_pair(input int ch);
        return (ch < 2) ? 0 : (ch / 2) - 1;
    endfunction

endpackage

// [hdl/ocdp_div.sv]
`timescale 1ns/1ps

// counter divider: pulses once per div_val input ticks
module ocdp_div #(
    parameter int W = 12
) (
    // clock and reset
    input  wire logic         mclk,
    input  wire logic         rst,
    // control
    input  wire logic         tick_in,
    input  wire logic         run,
    input  wire logic         restart,
    input  wire logic [W-1:0] div_val,
    input  wire logic [W-1:0] preload,
    // divided output
    output logic              tick_out,
    output logic              level_out
);
    typedef struct packed {
        logic [W-1:0] cnt;
        logic         tick;
        logic         lvl;
    } ocdp_div_s;

    ocdp_div_s    st_reg;
    ocdp_div_s    st_next;
    logic [W-1:0] last;
    logic [W-1:0] half;

    // zero divide value ticks as one, but its level stays low
    assign last = (div_val == '0) ? '0 : div_val - W'(1);
    assign half = W'(({1'b0, div_val} + (W+1)'(1)) >> 1);

    // next state: held at preload while idle, restarts from it
    always_comb
    begin
        st_next = st_reg;
        st_next.tick = 1'b0;
        if (!run || restart)
        begin
            st_next.cnt = preload;
            st_next.lvl = 1'b0;
        end
        else if (tick_in)
        begin
            if (st_reg.cnt >= last)
            begin
                st_next.cnt = '0;
                st_next.tick = 1'b1;
            end
            else
            begin
                st_next.cnt = st_reg.cnt + W'(1);
            end
            st_next.lvl = (st_next.cnt < half);
        end
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            st_reg <= '0;
        else
            st_reg <= st_next;
    end

    assign tick_out  = st_reg.tick;
    assign level_out = st_reg.lvl;
endmodule

// [hdl/ocdp_top.sv]
// What this block does
// - selector: bypass, divider, half, sysref, static
// - extra selector adds analog delay to sysref
// - static option: positive low, negative high
// - driver enable cleared puts output high impedance
// - channels 2,3,14,15: divider only, no sysref
// - pairs 4..13: divider then optional sysref divider
// - channels 0,1 chain divider and sysref divider
// - total division is post times channel times sysref
// - group divider off when both drivers off
// - channel 0/1 divider off with its driver
// - sysref chain reaches one pulse per second
// - sysref-capable dividers feed own sysref divider
// - replica needs pin enable and active source
// - replica source: enabled sysref with pair enable
// - replica tapped after static delay only
// - replica always continuous, never pulsed
// - channel and sysref divider paths have static delay, half path none
// - sysref path adds static, digital, analog delay
// - sync releases group dividers on same tick
`timescale 1ns/1ps

module ocdp_top
    import ocdp_pkg::*;
(
    // clock and reset
    input  wire logic                                mclk,
    input  wire logic                                rst,
    // post-divider clock per channel, as tick and level
    input  wire logic [ocdp_pkg::NUM_CH-1:0]         src_tick,
    input  wire logic [ocdp_pkg::NUM_CH-1:0]         src_level,
    // channel configuration
    input  wire ocdp_pkg::ocdp_ch_cfg_s [ocdp_pkg::NUM_CH-1:0] ch_cfg,
    input  wire logic [ocdp_pkg::NUM_PAIR-1:0]       pair_sysref_replicate_enable,
    // sync and sysref request events
    input  wire logic                                sync_req,
    input  wire logic                                sysref_req,
    // register port
    input  wire logic                                reg_wr,
    input  wire logic [7:0]                          reg_addr,
    input  wire logic [7:0]                          reg_wdata,
    output logic [7:0]                               reg_rdata,
    // general purpose pins
    input  wire logic [1:0]                          pin_output_enable,
    output logic                                     general_pin_one,
    output logic                                     general_pin_one_oe,
    output logic                                     general_pin_two,
    output logic                                     general_pin_two_oe,
    // output pin pairs
    output ocdp_pkg::ocdp_leg_s [ocdp_pkg::NUM_CH-1:0] out_leg
);
    import ocdp_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // state
    typedef struct packed {
        logic [NUM_CH-1:0]              div2;
        logic [NUM_CH-1:0]              aly;
        logic [NUM_CH-1:0][7:0]         sr_shift;
        ocdp_leg_s [NUM_CH-1:0]         leg;
        logic [3:0]                     gp;
        logic [5:2]                     ctrl;
        logic                           pend;
        logic                           go;
        logic [7:0]                     rdata;
    } ocdp_top_s;

    ocdp_top_s          st_reg;
    ocdp_top_s          st_next;
    logic [NUM_CH-1:0]  cd_run;
    logic [NUM_CH-1:0]  sr_run;
    logic [NUM_CH-1:0]  cd_restart;
    logic [NUM_CH-1:0]  sr_restart;
    logic [NUM_CH-1:0]  cd_tick;
    logic [NUM_CH-1:0]  cd_lvl;
    logic [NUM_CH-1:0]  sr_lvl;
    logic [NUM_CH-1:0]  rep_src;
    logic               rep_any;
    logic               rep_lvl;
    logic               sample_tick;
    logic [1:0]         req_mode;
    logic [1:0]         req_sel;

    assign req_mode = st_reg.ctrl[SR_MODE_LSB+1:SR_MODE_LSB];
    assign req_sel  = st_reg.ctrl[SR_SEL_LSB+1:SR_SEL_LSB];

    ////////////////////////////////////////////////////////////////////////
    // dividers per channel
    for (genvar c = 0; c < NUM_CH; c++)
    begin : g_ch
        // group power: shared pairs need both drivers off, singles their own
        if (c >= 4 && c <= 13)
        begin : g_pair
            assign cd_run[c] = (ch_cfg[c].output_driver_enable
                               | ch_cfg[c^1].output_driver_enable)
                               & ~ch_cfg[c].divider_power_down;
        end
        else
        begin : g_single
            assign cd_run[c] = ch_cfg[c].output_driver_enable
                               & ~ch_cfg[c].divider_power_down;
        end

        // sync restart of every enabled divider on one cycle
        assign cd_restart[c] = sync_req & ch_cfg[c].sync_enable;

        // channel divider with static offset as preload
        ocdp_div #(
            .W (CD_W)
        ) u_cd (
            .mclk      (mclk),
            .rst       (rst),
            .tick_in   (src_tick[c]),
            .run       (cd_run[c]),
            .restart   (cd_restart[c]),
            .div_val   (ch_cfg[c].channel_divide_value),
            .preload   (ch_cfg[c].cd_static_delay),
            .tick_out  (cd_tick[c]),
            .level_out (cd_lvl[c])
        );

        if (ocdp_has_sr(c))
        begin : g_sr
            // sysref divider counts channel divider ticks, so P x CD x SD
            assign sr_run[c]     = cd_run[c];
            assign sr_restart[c] = cd_restart[c] | st_reg.go;
            assign rep_src[c]    = sr_run[c]
                                   & pair_sysref_replicate_enable[ocdp_pair(c)];

            ocdp_div #(
                .W (SD_W)
            ) u_sd (
                .mclk      (mclk),
                .rst       (rst),
                .tick_in   (cd_tick[c]),
                .run       (sr_run[c]),
                .restart   (sr_restart[c]),
                .div_val   (ch_cfg[c].sysref_divide_value),
                .preload   (ch_cfg[c].sd_static_delay),
                .tick_out  (),
                .level_out (sr_lvl[c])
            );
        end
        else
        begin : g_nosr
            assign sr_run[c]     = 1'b0;
            assign sr_restart[c] = 1'b0;
            assign rep_src[c]    = 1'b0;
            assign sr_lvl[c]     = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // replica: static delayed sysref level, no digital or analog delay
    assign rep_any = |rep_src;
    assign rep_lvl = |(rep_src & sr_lvl);

    // request sample source picks one sysref-capable channel
    always_comb
    begin
        case (req_sel)
            2'h0:    sample_tick = src_tick[SR_SAMPLE_CH0];
            2'h1:    sample_tick = src_tick[SR_SAMPLE_CH1];
            2'h2:    sample_tick = src_tick[SR_SAMPLE_CH2];
            2'h3:    sample_tick = src_tick[SR_SAMPLE_CH3];
            default: sample_tick = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // next state
    always_comb
    begin
        logic lvl;
        lvl = 1'b0;
        st_next = st_reg;

        // register write and registered read back
        if (reg_wr && reg_addr == SR_CTRL_ADDR)
            st_next.ctrl = reg_wdata[5:2];
        st_next.rdata = '0;
        if (reg_addr == SR_CTRL_ADDR)
        begin
            st_next.rdata[5:2] = st_reg.ctrl;
            st_next.rdata[SR_PEND_BIT] = st_reg.pend;
        end

        // sysref request: direct, or held until the sample tick
        if (req_mode == SR_MODE_RESAMPLE)
        begin
            st_next.go   = st_reg.pend & sample_tick;
            st_next.pend = (st_reg.pend & ~st_next.go) | sysref_req;
        end
        else
        begin
            st_next.go   = sysref_req;
            st_next.pend = 1'b0;
        end

        // per channel output selection
        for (int c = 0; c < NUM_CH; c++)
        begin
            if (src_tick[c] && cd_run[c])
                st_next.div2[c] = ~st_reg.div2[c];
            else if (!cd_run[c])
                st_next.div2[c] = 1'b0;
            st_next.sr_shift[c] = {st_reg.sr_shift[c][6:0], sr_lvl[c]};
            st_next.aly[c] = st_reg.sr_shift[c][ch_cfg[c].sysref_digital_delay];
            case (ch_cfg[c].channel_divider_select)
                OCDP_SEL_BYPASS:  lvl = src_level[c];
                OCDP_SEL_CHANNEL_DIVIDER_SELECT:   lvl = cd_lvl[c];
                OCDP_SEL_HALF:    lvl = st_reg.div2[c];
                OCDP_SEL_SYSREF:  lvl = st_reg.sr_shift[c][ch_cfg[c].sysref_digital_delay];
                OCDP_SEL_SR_ANALOG_DELAY: lvl = st_reg.aly[c];
                default:          lvl = 1'b0;
            endcase
            if (ch_cfg[c].channel_divider_select == OCDP_SEL_STATIC)
            begin
                st_next.leg[c].positive_leg = 1'b0;
                st_next.leg[c].negative_leg = 1'b1;
            end
            else
            begin
                st_next.leg[c].positive_leg = lvl;
                st_next.leg[c].negative_leg = ~lvl;
            end
            st_next.leg[c].oe = ch_cfg[c].output_driver_enable;
        end

        // replica pins: continuous level, never gated by pulse mode
        st_next.gp[0] = rep_lvl;
        st_next.gp[1] = pin_output_enable[0] & rep_any;
        st_next.gp[2] = rep_lvl;
        st_next.gp[3] = pin_output_enable[1] & rep_any;
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            st_reg      <= '0;
            st_reg.ctrl <= SR_CTRL_RESET[5:2];
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs
    assign out_leg            = st_reg.leg;
    assign reg_rdata          = st_reg.rdata;
    assign general_pin_one    = st_reg.gp[0];
    assign general_pin_one_oe = st_reg.gp[1];
    assign general_pin_two    = st_reg.gp[2];
    assign general_pin_two_oe = st_reg.gp[3];

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    property p_static_level;
        ch_cfg[0].channel_divider_select == OCDP_SEL_STATIC
        |=> !out_leg[0].positive_leg && out_leg[0].negative_leg;
    endproperty
    a_static_level: assert property (p_static_level)
        else $error("static option did not hold legs");

    property p_disable_hiz;
        !ch_cfg[0].output_driver_enable |=> !out_leg[0].oe;
    endproperty
    a_disable_hiz: assert property (p_disable_hiz)
        else $error("disabled driver not high impedance");

    property p_drive_on;
        ch_cfg[0].output_driver_enable |=> out_leg[0].oe;
    endproperty
    a_drive_on: assert property (p_drive_on)
        else $error("enabled driver not driven");

    property p_bypass;
        ch_cfg[3].channel_divider_select == OCDP_SEL_BYPASS
        |=> out_leg[3].positive_leg == $past(src_level[3]);
    endproperty
    a_bypass: assert property (p_bypass)
        else $error("bypass did not follow source level");

    property p_no_sr_ch;
        1'b1 |-> !sr_run[2] && !sr_run[3] && !sr_run[14] && !sr_run[15];
    endproperty
    a_no_sr_ch: assert property (p_no_sr_ch)
        else $error("sysref divider on divider-only channel");

    property p_group_off;
        !ch_cfg[4].output_driver_enable && !ch_cfg[5].output_driver_enable
        |=> !cd_tick[4];
    endproperty
    a_group_off: assert property (p_group_off)
        else $error("group divider ran with both drivers off");

    property p_ch0_off;
        !ch_cfg[0].output_driver_enable [*2] |=> !cd_tick[0] && !sr_lvl[0];
    endproperty
    a_ch0_off: assert property (p_ch0_off)
        else $error("channel zero divider ran while disabled");

    property p_pd_idle;
        ch_cfg[0].divider_power_down |=> !cd_tick[0] && !cd_lvl[0];
    endproperty
    a_pd_idle: assert property (p_pd_idle)
        else $error("powered down divider left its preload");

    property p_pin_oe;
        pin_output_enable[0] && rep_any |=> general_pin_one_oe;
    endproperty
    a_pin_oe: assert property (p_pin_oe)
        else $error("replica pin not enabled");

    property p_pin_src;
        !rep_any |=> !general_pin_one_oe && !general_pin_two_oe;
    endproperty
    a_pin_src: assert property (p_pin_src)
        else $error("replica pin enabled without source");

    property p_resample_wait;
        req_mode == SR_MODE_RESAMPLE && sysref_req && !st_reg.pend
        |=> !st_reg.go ##0 st_reg.pend;
    endproperty
    a_resample_wait: assert property (p_resample_wait)
        else $error("resampled request not held");

    property p_direct_go;
        req_mode != SR_MODE_RESAMPLE && sysref_req |=> st_reg.go;
    endproperty
    a_direct_go: assert property (p_direct_go)
        else $error("direct request did not restart sysref");

    property p_sync_clear;
        sync_req && ch_cfg[0].sync_enable && ch_cfg[1].sync_enable
        |=> !cd_tick[0] && !cd_tick[1] && !cd_lvl[0] && !cd_lvl[1];
    endproperty
    a_sync_clear: assert property (p_sync_clear)
        else $error("sync did not restart group dividers");
endmodule

// [testbench/ocdp_rx_model.sv]
`timescale 1ns/1ps

// clock receiver: measures the period of a received clock line in mclk cycles
module ocdp_rx_model
(
    // clock and reset
    input  wire logic       mclk,
    input  wire logic       rst,
    // received line, ignored while not driven
    input  wire logic       line,
    input  wire logic       line_oe,
    input  wire logic       clr,
    // measured results
    output logic [7:0]      period,
    output logic [7:0]      rises
);
    logic [7:0] cnt;
    logic       prev;

    ////////////////////////////////////////////////////////////////////////
    // a floating line is seen as no edge, so a hi-z output never counts
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst || clr)
        begin
            cnt    <= 8'h00;
            prev   <= 1'b0;
            period <= 8'h00;
            rises  <= 8'h00;
        end
        else
        begin
            prev <= line_oe & line;
            cnt  <= cnt + 8'h01;
            if (line_oe && line && !prev)
            begin
                if (rises != 8'h00)
                    period <= cnt;
                cnt   <= 8'h01;
                rises <= rises + 8'h01;
            end
        end
    end
endmodule

// [testbench/output_channel_divider_path_tb.sv]
`timescale 1ns/1ps

module output_channel_divider_path_tb;
    import ocdp_pkg::*;

    logic                      mclk;
    logic                      rst;
    logic [NUM_CH-1:0]         src_tick;
    logic [NUM_CH-1:0]         src_level;
    ocdp_ch_cfg_s [NUM_CH-1:0] ch_cfg;
    logic [NUM_PAIR-1:0]       pair_en;
    logic                      sync_req;
    logic                      sysref_req;
    logic                      reg_wr;
    logic [7:0]                reg_addr;
    logic [7:0]                reg_wdata;
    logic [7:0]                reg_rdata;
    logic [1:0]                pin_en;
    logic                      pin1;
    logic                      pin1_oe;
    logic                      pin2;
    logic                      pin2_oe;
    ocdp_leg_s [NUM_CH-1:0]    out_leg;
    logic [3:0]                mon_ch;
    logic                      clr;
    logic [7:0]                leg_period;
    logic [7:0]                leg_rises;
    logic [7:0]                pin_period;
    logic [7:0]                pin2_period;
    logic [7:0]                rd;
    logic                      p0_prev;
    logic                      exp_bit;
    int                        miscompares;
    int                        samples_checked;
    ocdp_sel_e                 sel_tab [5];
    logic [7:0]                per_tab [5];

    ////////////////////////////////////////////////////////////////////////
    // design, receivers on one monitored leg and on pins one and two
    ocdp_top i_ocdp_top (
        .mclk(mclk), .rst(rst), .src_tick(src_tick), .src_level(src_level),
        .ch_cfg(ch_cfg), .pair_sysref_replicate_enable(pair_en),
        .sync_req(sync_req), .sysref_req(sysref_req), .reg_wr(reg_wr),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .pin_output_enable(pin_en), .general_pin_one(pin1),
        .general_pin_one_oe(pin1_oe), .general_pin_two(pin2),
        .general_pin_two_oe(pin2_oe), .out_leg(out_leg));

    ocdp_rx_model i_ocdp_rx_model (
        .mclk(mclk), .rst(rst), .line(out_leg[mon_ch].positive_leg),
        .line_oe(out_leg[mon_ch].oe), .clr(clr), .period(leg_period), .rises(leg_rises));

    ocdp_rx_model i_ocdp_rx_model_pin (
        .mclk(mclk), .rst(rst), .line(pin1), .line_oe(pin1_oe), .clr(clr),
        .period(pin_period), .rises());

    ocdp_rx_model i_ocdp_rx_model_pin2 (
        .mclk(mclk), .rst(rst), .line(pin2), .line_oe(pin2_oe), .clr(clr),
        .period(pin2_period), .rises());

    ////////////////////////////////////////////////////////////////////////
    // clock and a bypass source level toggling every cycle
    initial
    begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    always @(negedge mclk)
        src_level <= rst ? '0 : ~src_level;

    ////////////////////////////////////////////////////////////////////////
    // compares, bus access and helpers
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_leg(input ocdp_leg_s got, input ocdp_leg_s exp);
        samples_checked++;
        if (got !== exp)
        begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk);
        reg_wr    = 1'b1;
        reg_addr  = a;
        reg_wdata = d;
        @(negedge mclk);
        reg_wr = 1'b0;
    endtask

    task automatic reg_read(input logic [7:0] a);
        @(negedge mclk);
        reg_addr = a;
        @(negedge mclk);
        rd = reg_rdata;
    endtask

    task automatic set_ch(input int ch, input ocdp_sel_e s, input logic [11:0] cd,
                          input logic [19:0] sd, input logic [11:0] pre,
                          input logic en, input logic pd);
        ch_cfg[ch] = '{s, cd, sd, pre, 20'h0, 3'h0, en, pd, 1'b1};
    endtask

    task automatic measure(input int ch);
        @(negedge mclk);
        mon_ch = ch[3:0];
        clr    = 1'b1;
        @(negedge mclk);
        clr = 1'b0;
        repeat (30) @(negedge mclk);
    endtask

    task automatic pulse_req(input logic is_sync);
        @(negedge mclk);
        if (is_sync)
            sync_req = 1'b1;
        else
            sysref_req = 1'b1;
        @(negedge mclk);
        sync_req   = 1'b0;
        sysref_req = 1'b0;
    endtask

    // leg one against leg zero, one cycle behind or inverted
    task automatic sync_cmp(input logic lag, input logic inv);
        pulse_req(1'b1);
        repeat (4) @(negedge mclk);
        p0_prev = out_leg[0].positive_leg;
        @(negedge mclk);
        for (int i = 0; i < 12; i++)
        begin
            exp_bit = inv ^ (lag ? p0_prev : out_leg[0].positive_leg);
            chk_byte({7'h0, out_leg[1].positive_leg}, {7'h0, exp_bit});
            p0_prev = out_leg[0].positive_leg;
            @(negedge mclk);
        end
    endtask

    task automatic close_out;
        if (miscompares == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // guard against a hung run
    initial
    begin
        repeat (20000) @(posedge mclk);
        miscompares++;
        close_out();
    end

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial
    begin
        rst = 1'b1;
        src_tick = '1;
        ch_cfg = '0;
        pair_en = '0;
        sync_req = 1'b0;
        sysref_req = 1'b0;
        reg_wr = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        pin_en = 2'h0;
        mon_ch = 4'h0;
        clr = 1'b0;
        miscompares = 0;
        samples_checked = 0;
        sel_tab = '{OCDP_SEL_BYPASS, OCDP_SEL_CHANNEL_DIVIDER_SELECT, OCDP_SEL_HALF, OCDP_SEL_SYSREF,
                    OCDP_SEL_SR_ANALOG_DELAY};
        per_tab = '{8'h02, 8'h03, 8'h02, 8'h06, 8'h06};
        repeat (8) @(negedge mclk);
        rst = 1'b0;
        // reset state and register access
        chk_leg(out_leg[0], '{1'b0, 1'b0, 1'b0});
        reg_read(SR_CTRL_ADDR);
        chk_byte(rd, SR_CTRL_RESET);
        reg_write(SR_CTRL_ADDR, 8'hff);
        reg_read(SR_CTRL_ADDR);
        chk_byte(rd, 8'h3c);
        reg_write(8'h1b, 8'h00);
        reg_read(SR_CTRL_ADDR);
        chk_byte(rd, 8'h3c);
        reg_read(8'h1b);
        chk_byte(rd, 8'h00);
        // every selector option, cd 3 sd 2
        for (int k = 0; k < 5; k++)
        begin
            set_ch(0, sel_tab[k], 12'h3, 20'h2, 12'h0, 1'b1, 1'b0);
            measure(0);
            chk_byte(leg_period, per_tab[k]);
        end
        set_ch(0, OCDP_SEL_STATIC, 12'h3, 20'h2, 12'h0, 1'b1, 1'b0);
        repeat (3) @(negedge mclk);
        chk_leg(out_leg[0], '{1'b0, 1'b1, 1'b1});
        ch_cfg[0].output_driver_enable = 1'b0;
        repeat (3) @(negedge mclk);
        chk_leg(out_leg[0], '{1'b0, 1'b1, 1'b0});
        // plain divider channel and a pair channel with sysref
        set_ch(2, OCDP_SEL_CHANNEL_DIVIDER_SELECT, 12'h5, 20'h1, 12'h0, 1'b1, 1'b0);
        measure(2);
        chk_byte(leg_period, 8'h05);
        set_ch(4, OCDP_SEL_SYSREF, 12'h3, 20'h4, 12'h0, 1'b1, 1'b0);
        measure(4);
        chk_byte(leg_period, 8'h0c);
        // host power down then power up
        set_ch(0, OCDP_SEL_CHANNEL_DIVIDER_SELECT, 12'h4, 20'h1, 12'h0, 1'b1, 1'b1);
        measure(0);
        chk_byte(leg_rises, 8'h00);
        ch_cfg[0].divider_power_down = 1'b0;
        measure(0);
        chk_byte(leg_period, 8'h04);
        // sync alignment with analog delay and with static delay
        set_ch(0, OCDP_SEL_SYSREF, 12'h2, 20'h3, 12'h0, 1'b1, 1'b0);
        set_ch(1, OCDP_SEL_SR_ANALOG_DELAY, 12'h2, 20'h3, 12'h0, 1'b1, 1'b0);
        sync_cmp(1'b1, 1'b0);
        set_ch(0, OCDP_SEL_CHANNEL_DIVIDER_SELECT, 12'h4, 20'h1, 12'h0, 1'b1, 1'b0);
        set_ch(1, OCDP_SEL_CHANNEL_DIVIDER_SELECT, 12'h4, 20'h1, 12'h2, 1'b1, 1'b0);
        sync_cmp(1'b0, 1'b1);
        // replica onto pins one and two
        set_ch(0, OCDP_SEL_SYSREF, 12'h2, 20'h3, 12'h0, 1'b1, 1'b0);
        ch_cfg[0].sysref_digital_delay = 3'h7;
        ch_cfg[1].output_driver_enable = 1'b0;
        pair_en = 6'h01;
        pin_en  = 2'h3;
        measure(0);
        chk_byte({6'h0, pin2_oe, pin1_oe}, 8'h03);
        chk_byte(pin2_period, 8'h06);
        chk_byte(pin_period, 8'h06);
        chk_byte(leg_period, 8'h06);
        pair_en = 6'h00;
        repeat (3) @(negedge mclk);
        chk_byte({6'h0, pin2_oe, pin1_oe}, 8'h00);
        // sysref request, direct then resampled on channel 0 ticks
        src_tick = 16'hfffe;
        reg_write(SR_CTRL_ADDR, 8'h00);
        pulse_req(1'b0);
        repeat (2) @(negedge mclk);
        reg_read(SR_CTRL_ADDR);
        chk_byte(rd, 8'h00);
        reg_write(SR_CTRL_ADDR, 8'h30);
        pulse_req(1'b0);
        repeat (2) @(negedge mclk);
        reg_read(SR_CTRL_ADDR);
        chk_byte(rd, 8'h31);
        src_tick = '1;
        repeat (3) @(negedge mclk);
        reg_read(SR_CTRL_ADDR);
        chk_byte(rd, 8'h30);
        // resampled on channel 4 ticks through sample select 1
        src_tick = 16'hffef;
        reg_write(SR_CTRL_ADDR, 8'h34);
        pulse_req(1'b0);
        repeat (2) @(negedge mclk);
        reg_read(SR_CTRL_ADDR);
        chk_byte(rd, 8'h35);
        src_tick = '1;
        repeat (3) @(negedge mclk);
        reg_read(SR_CTRL_ADDR);
        chk_byte(rd, 8'h34);
        close_out();
    end
endmodule
